/* File: design/core_access_bridge.sv */
// AHB to OPB core access bridge: direct, indirect register and process RAM paths.
// Assumes core clock phase-aligned with clk at CLK_RATIO:1; control bits are plain ports.
//
// Contract
// - AHB slave upstream, OPB master, ratio up to 16
// - Low range access launches one OPB access
// - Direct read: busy during cycle, then data
// - Direct write: busy during cycle, drive data
// - Indirect read: abort, setup, busy, then data
// - Indirect write: abort, setup, busy cleared when done
// - One command write starts the operation
// - Byte lanes follow size and address
// - Read window starts reads into TX FIFO
// - Read remaining and pointer track progress
// - First and last word lanes from address, length
// - Read abort waits cycle, flushes TX FIFO
// - Write window, start bit, writes from RX FIFO
// - No OPB write while RX FIFO empty
// - After each acknowledge, wait for RX data
// - Write remaining and pointer track progress
// - Write abort waits cycle, flushes RX FIFO
// - Zero writes ignored; abort clears with busy
`timescale 1ns/10ps
`default_nettype none

module core_access_bridge #(
  parameter int CLK_RATIO  = bridge_pkg::CLK_RATIO_DEF,
  parameter int FIFO_DEPTH = bridge_pkg::FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // OPB master
  output logic             opb_select,
  output logic             opb_rnw,
  output logic [15:0]      opb_abus,
  output logic [3:0]       opb_be,
  output logic [31:0]      opb_dbus_out,
  input  wire logic [31:0] opb_dbus_in,
  input  wire logic        opb_xferack,
  // Core access command and data
  input  wire logic        cmd_wr,
  input  wire logic        cmd_busy_in,
  input  wire logic        cmd_direction_in,
  input  wire logic        cmd_abort_in,
  input  wire logic [2:0]  cmd_byte_count_in,
  input  wire logic [15:0] cmd_target_in,
  input  wire logic        data_wr,
  input  wire logic [31:0] data_in,
  output logic             core_access_busy,
  output logic             core_access_abort,
  output logic             core_access_direction,
  output logic [15:0]      core_access_target,
  output logic [2:0]       core_access_byte_count,
  output logic [31:0]      core_access_data,
  // Process RAM read
  input  wire logic        read_window_wr,
  input  wire logic [15:0] read_window_start,
  input  wire logic [15:0] read_window_length,
  input  wire logic        read_abort_wr,
  output logic             process_ram_read_busy,
  output logic             process_ram_read_abort,
  output logic [15:0]      process_ram_read_remaining,
  output logic [15:0]      process_ram_read_pointer,
  output logic [31:0]      tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  // Process RAM write
  input  wire logic        write_window_wr,
  input  wire logic [15:0] write_window_start,
  input  wire logic [15:0] write_window_length,
  input  wire logic        write_start_wr,
  input  wire logic        write_abort_wr,
  output logic             process_ram_write_busy,
  output logic             process_ram_write_abort,
  output logic [15:0]      process_ram_write_remaining,
  output logic [15:0]      process_ram_write_pointer,
  input  wire logic [31:0] rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready
);
  typedef enum logic [2:0] {ST_IDLE, ST_DIRECT, ST_CORE, ST_PRD, ST_PWR} path_e;

  localparam int CW = $clog2(bridge_pkg::CLK_RATIO_MAX) + 1;

  path_e       state_q;
  logic [CW-1:0] div_q;
  logic        core_en;
  logic        dir_pend_q;
  logic [15:0] dir_addr_q;
  logic [3:0]  dir_be_q;
  logic [31:0] hrdata_q;
  logic        req_start_q;
  logic        req_rnw_q;
  logic [15:0] req_addr_q;
  logic [3:0]  req_be_q;
  logic [31:0] req_wdata_q;
  logic        done;
  logic [31:0] rdata;
  logic        tx_flush;
  logic        tx_push;
  logic        tx_in_ready;
  logic        rx_flush;
  logic        rx_pop;
  logic        rx_out_valid;
  logic [31:0] rx_out_data;
  logic [2:0]  rd_n;
  logic [2:0]  wr_n;
  logic        addr_phase;
  logic        core_go;
  logic        rd_go;
  logic        wr_go;

  opb_req_if req_if ();

  assign req_if.start = req_start_q;
  assign req_if.rnw   = req_rnw_q;
  assign req_if.addr  = req_addr_q;
  assign req_if.be    = req_be_q;
  assign req_if.wdata = req_wdata_q;
  assign done         = req_if.done;
  assign rdata        = req_if.rdata;

  // Core clock as an enable; phase-locked, so OPB inputs need no synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst || div_q == CW'(CLK_RATIO - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign core_en = (div_q == CW'(CLK_RATIO - 1));

  opb_cycle u_opb (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .core_en      (core_en),
    .req          (req_if.engine),
    .opb_select   (opb_select),
    .opb_rnw      (opb_rnw),
    .opb_abus     (opb_abus),
    .opb_be       (opb_be),
    .opb_dbus_out (opb_dbus_out),
    .opb_dbus_in  (opb_dbus_in),
    .opb_xferack  (opb_xferack)
  );

  bridge_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (tx_flush),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   (rdata),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  bridge_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (rx_flush),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   (rx_data),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .out_data  (rx_out_data)
  );

  // AHB side: only the low range stalls; elsewhere a zero-wait OKAY
  assign addr_phase = hsel && htrans[1] && hready && (haddr <= bridge_pkg::DIRECT_TOP);
  assign hreadyout  = !dir_pend_q;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dir_pend_q <= 1'b0;
      dir_addr_q <= bridge_pkg::PTR_RST;
      dir_be_q   <= 4'h0;
      hrdata_q   <= bridge_pkg::DATA_RST;
    end else if (addr_phase) begin
      dir_pend_q <= 1'b1;
      dir_addr_q <= haddr[15:0];
      dir_be_q   <= bridge_pkg::lane_mask(haddr[1:0], bridge_pkg::ahb_bytes(hsize));
    end else if (state_q == ST_DIRECT && done) begin
      dir_pend_q <= 1'b0;
      hrdata_q   <= rdata;
    end
  end

  assign rd_n    = bridge_pkg::word_bytes(process_ram_read_pointer[1:0], process_ram_read_remaining);
  assign wr_n    = bridge_pkg::word_bytes(process_ram_write_pointer[1:0], process_ram_write_remaining);
  assign core_go = core_access_busy && !dir_pend_q;
  assign rd_go   = process_ram_read_busy && !process_ram_read_abort && tx_in_ready;
  assign wr_go   = process_ram_write_busy && !process_ram_write_abort && rx_out_valid;

  // Path arbitration; one OPB cycle in flight at a time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      req_start_q <= 1'b0;
      req_rnw_q   <= 1'b1;
      req_addr_q  <= bridge_pkg::PTR_RST;
      req_be_q    <= 4'h0;
      req_wdata_q <= bridge_pkg::DATA_RST;
    end else begin
      req_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (core_go) begin
            state_q     <= ST_CORE;
            req_start_q <= 1'b1;
            req_rnw_q   <= core_access_direction;
            req_addr_q  <= core_access_target;
            req_be_q    <= bridge_pkg::lane_mask(core_access_target[1:0], core_access_byte_count);
            req_wdata_q <= core_access_data;
          end else if (dir_pend_q) begin
            state_q     <= ST_DIRECT;
            req_start_q <= 1'b1;
            req_rnw_q   <= core_access_direction;
            req_addr_q  <= dir_addr_q;
            req_be_q    <= dir_be_q;
            req_wdata_q <= hwdata;
          end else if (rd_go) begin
            state_q     <= ST_PRD;
            req_start_q <= 1'b1;
            req_rnw_q   <= 1'b1;
            req_addr_q  <= {process_ram_read_pointer[15:2], 2'b00};
            req_be_q    <= bridge_pkg::lane_mask(process_ram_read_pointer[1:0], rd_n);
          end else if (wr_go) begin
            state_q     <= ST_PWR;
            req_start_q <= 1'b1;
            req_rnw_q   <= 1'b0;
            req_addr_q  <= {process_ram_write_pointer[15:2], 2'b00};
            req_be_q    <= bridge_pkg::lane_mask(process_ram_write_pointer[1:0], wr_n);
            req_wdata_q <= rx_out_data;
          end
        end
        ST_DIRECT, ST_CORE, ST_PRD, ST_PWR: begin
          if (done) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Indirect core access command, busy and abort
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_access_busy       <= 1'b0;
      core_access_abort      <= 1'b0;
      core_access_direction  <= 1'b0;
      core_access_target     <= bridge_pkg::PTR_RST;
      core_access_byte_count <= bridge_pkg::SIZE_RST;
    end else begin
      if (state_q == ST_IDLE && !core_go && dir_pend_q) begin
        core_access_busy <= 1'b1;
      end else if ((state_q == ST_DIRECT || state_q == ST_CORE) && done) begin
        core_access_busy <= 1'b0;
      end else if (cmd_wr && cmd_abort_in && state_q != ST_DIRECT) begin
        core_access_busy <= 1'b0;
      end else if (cmd_wr && cmd_busy_in && !core_access_busy && state_q != ST_CORE) begin
        core_access_busy       <= 1'b1;
        core_access_direction  <= cmd_direction_in;
        core_access_target     <= cmd_target_in;
        core_access_byte_count <= cmd_byte_count_in;
      end else if (cmd_wr && !core_access_busy) begin
        core_access_direction  <= cmd_direction_in;
        core_access_target     <= cmd_target_in;
        core_access_byte_count <= cmd_byte_count_in;
      end
      if (cmd_wr && cmd_abort_in && state_q != ST_DIRECT) begin
        core_access_abort <= 1'b1;
      end else if (!core_access_busy) begin
        core_access_abort <= 1'b0;
      end
    end
  end

  // Data register; an aborted cycle's read result is dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_access_data <= bridge_pkg::DATA_RST;
    end else if (state_q == ST_CORE && done && core_access_busy && core_access_direction) begin
      core_access_data <= bridge_pkg::keep_lanes(rdata, req_be_q);
    end else if (data_wr && !core_access_busy) begin
      core_access_data <= data_in;
    end
  end

  // Process RAM block read
  assign tx_push  = (state_q == ST_PRD) && done && !process_ram_read_abort;
  assign tx_flush = process_ram_read_busy && process_ram_read_abort
                    && (state_q != ST_PRD || done);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      process_ram_read_busy      <= 1'b0;
      process_ram_read_abort     <= 1'b0;
      process_ram_read_pointer   <= bridge_pkg::PTR_RST;
      process_ram_read_remaining <= bridge_pkg::LEN_RST;
    end else if (tx_flush) begin
      process_ram_read_busy  <= 1'b0;
      process_ram_read_abort <= 1'b0;
    end else if (tx_push) begin
      process_ram_read_pointer   <= {process_ram_read_pointer[15:2] + 14'h0001, 2'b00};
      process_ram_read_remaining <= process_ram_read_remaining - {13'h0000, rd_n};
      process_ram_read_busy      <= (process_ram_read_remaining != {13'h0000, rd_n});
      if (read_abort_wr) begin
        process_ram_read_abort <= 1'b1;
      end
    end else if (read_window_wr && !process_ram_read_busy) begin
      process_ram_read_pointer   <= read_window_start;
      process_ram_read_remaining <= read_window_length;
      process_ram_read_busy      <= (read_window_length != bridge_pkg::LEN_RST);
    end else if (read_abort_wr && process_ram_read_busy) begin
      process_ram_read_abort <= 1'b1;
    end
  end

  // Process RAM block write
  assign rx_pop   = (state_q == ST_PWR) && done;
  assign rx_flush = process_ram_write_busy && process_ram_write_abort
                    && (state_q != ST_PWR || done);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      process_ram_write_busy      <= 1'b0;
      process_ram_write_abort     <= 1'b0;
      process_ram_write_pointer   <= bridge_pkg::PTR_RST;
      process_ram_write_remaining <= bridge_pkg::LEN_RST;
    end else if (rx_flush) begin
      process_ram_write_busy  <= 1'b0;
      process_ram_write_abort <= 1'b0;
    end else if (rx_pop) begin
      process_ram_write_pointer   <= {process_ram_write_pointer[15:2] + 14'h0001, 2'b00};
      process_ram_write_remaining <= process_ram_write_remaining - {13'h0000, wr_n};
      process_ram_write_busy      <= (process_ram_write_remaining != {13'h0000, wr_n});
      if (write_abort_wr) begin
        process_ram_write_abort <= 1'b1;
      end
    end else if (write_window_wr && !process_ram_write_busy) begin
      process_ram_write_pointer   <= write_window_start;
      process_ram_write_remaining <= write_window_length;
    end else if (write_start_wr && !process_ram_write_busy) begin
      process_ram_write_busy <= (process_ram_write_remaining != bridge_pkg::LEN_RST);
    end else if (write_abort_wr && process_ram_write_busy) begin
      process_ram_write_abort <= 1'b1;
    end
  end
endmodule // core_access_bridge

`default_nettype wire

/* File: design/bridge_pkg.sv */
// Shared constants and helpers for the AHB to OPB core access bridge.
// Assumes a 32-bit AHB-Lite host and a 16-bit OPB address space on the core side.
package bridge_pkg;
  localparam int ADDR_W        = 16;
  localparam int DATA_W        = 32;
  localparam int BE_W          = 4;
  localparam int FIFO_DEPTH    = 4;
  localparam int CLK_RATIO_MAX = 16;
  localparam int CLK_RATIO_DEF = 4;
  // Direct core register window upper bound
  localparam logic [31:0] DIRECT_TOP = 32'h00000FFF;

  localparam logic [2:0]  SIZE_BYTE = 3'h1;
  localparam logic [2:0]  SIZE_HALF = 3'h2;
  localparam logic [2:0]  SIZE_WORD = 3'h4;
  localparam logic [2:0]  WORD_BYTES = 3'h4;

  localparam logic [15:0] PTR_RST  = 16'h0000;
  localparam logic [15:0] LEN_RST  = 16'h0000;
  localparam logic [31:0] DATA_RST = 32'h00000000;
  localparam logic [2:0]  SIZE_RST = 3'h0;

  // Byte enables for n bytes starting at lane off; other counts give none
  function automatic logic [3:0] lane_mask(input logic [1:0] off, input logic [2:0] n);
    logic [3:0] m;
    case (n)
      3'h1:    m = 4'h1;
      3'h2:    m = 4'h3;
      3'h3:    m = 4'h7;
      3'h4:    m = 4'hF;
      default: m = 4'h0;
    endcase
    return m << off;
  endfunction

  // Bytes moved by one word of a block transfer
  function automatic logic [2:0] word_bytes(input logic [1:0] off, input logic [15:0] rem);
    logic [2:0] room;
    room = WORD_BYTES - {1'b0, off};
    if (rem < {13'h0000, room}) begin
      return rem[2:0];
    end
    return room;
  endfunction

  // AHB HSIZE to byte count
  function automatic logic [2:0] ahb_bytes(input logic [2:0] hsize);
    case (hsize)
      3'h0:    return SIZE_BYTE;
      3'h1:    return SIZE_HALF;
      default: return SIZE_WORD;
    endcase
  endfunction

  // Keep only the enabled lanes of a word
  function automatic logic [31:0] keep_lanes(input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = be[i] ? d[i*8 +: 8] : 8'h00;
    end
    return r;
  endfunction

endpackage

/* File: design/opb_req_if.sv */
// One OPB cycle request between the bridge control and the OPB cycle engine.
// Assumes a single request outstanding at a time.
`timescale 1ns/10ps
`default_nettype none

interface opb_req_if;
  logic        start;
  logic        rnw;
  logic [15:0] addr;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic        done;
  logic [31:0] rdata;

  modport requester (output start, output rnw, output addr, output be, output wdata,
                     input done, input rdata);
  modport engine    (input start, input rnw, input addr, input be, input wdata,
                     output done, output rdata);
endinterface

`default_nettype wire

/* File: design/bridge_fifo.sv */
// Flop-based FIFO with valid/ready on both sides and a synchronous flush.
// Assumes one clock; flush wins over a push in the same cycle.
`timescale 1ns/10ps
`default_nettype none

module bridge_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end
endmodule // bridge_fifo

`default_nettype wire

/* File: design/opb_cycle.sv */
// OPB master cycle engine: runs one OPB read or write per request.
// Assumes the core side advances only on core_en, a pulse every N fast clocks.
`timescale 1ns/10ps
`default_nettype none

module opb_cycle (
  input  wire logic     clk,
  input  wire logic     sys_rst,
  input  wire logic     core_en,
  opb_req_if.engine     req,
  output logic          opb_select,
  output logic          opb_rnw,
  output logic [15:0]   opb_abus,
  output logic [3:0]    opb_be,
  output logic [31:0]   opb_dbus_out,
  input  wire logic [31:0] opb_dbus_in,
  input  wire logic     opb_xferack
);
  typedef enum logic [1:0] {CY_IDLE, CY_PEND, CY_ACT} cycle_e;

  cycle_e      state_q;
  logic        done_q;
  logic [31:0] rdata_q;

  assign req.done  = done_q;
  assign req.rdata = rdata_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q      <= CY_IDLE;
      done_q       <= 1'b0;
      rdata_q      <= 32'h00000000;
      opb_select   <= 1'b0;
      opb_rnw      <= 1'b1;
      opb_abus     <= 16'h0000;
      opb_be       <= 4'h0;
      opb_dbus_out <= 32'h00000000;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        CY_IDLE: begin
          if (req.start) begin
            opb_rnw      <= req.rnw;
            opb_abus     <= req.addr;
            opb_be       <= req.be;
            opb_dbus_out <= req.rnw ? 32'h00000000 : req.wdata;
            state_q      <= CY_PEND;
          end
        end
        // Select only on a core edge so the core sees a full cycle
        CY_PEND: begin
          if (core_en) begin
            opb_select <= 1'b1;
            state_q    <= CY_ACT;
          end
        end
        CY_ACT: begin
          if (core_en && opb_xferack) begin
            opb_select   <= 1'b0;
            opb_be       <= 4'h0;
            opb_dbus_out <= 32'h00000000;
            rdata_q      <= opb_dbus_in;
            done_q       <= 1'b1;
            state_q      <= CY_IDLE;
          end
        end
        default: state_q <= CY_IDLE;
      endcase
    end
  end
endmodule // opb_cycle

`default_nettype wire

/* File: sim/core_access_bridge_assertions.sv */
// Port assertions for core_access_bridge.
// Bound by the bench; one clock, sync reset.
`timescale 1ns/10ps
`default_nettype none
module core_access_bridge_assertions (
  input wire logic clk, sys_rst, hsel, hready, hreadyout, opb_select, opb_xferack, tx_valid,
  input wire logic core_access_busy, core_access_abort, process_ram_read_busy, process_ram_read_abort,
  input wire logic process_ram_write_busy,
  input wire logic [1:0] htrans,
  input wire logic [15:0] opb_abus, process_ram_read_remaining, process_ram_write_remaining,
  input wire logic [31:0] haddr
);
  logic take;
  logic idle;
  assign take = hsel && htrans[1] && hready && haddr <= 32'h00000FFF;
  assign idle = !core_access_busy && !opb_select && !process_ram_read_busy && !process_ram_write_busy;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_direct_stall: assert property (take |=> !hreadyout)
    else $error("direct access not stalled");
  a_direct_busy: assert property (take && idle |-> ##2 core_access_busy)
    else $error("busy not raised");
  a_ready_after: assert property ($rose(hreadyout) |-> !core_access_busy)
    else $error("ready while busy");
  a_abort_clear: assert property (core_access_abort && !core_access_busy |=> !core_access_abort)
    else $error("abort stuck");
  a_opb_hold: assert property (opb_select && !opb_xferack |=> opb_select && $stable(opb_abus))
    else $error("opb cycle dropped");
  a_rd_step: assert property (process_ram_read_busy && $past(process_ram_read_busy) |->
    $past(process_ram_read_remaining) - process_ram_read_remaining <= 16'h0004) else $error("read length jump");
  a_wr_step: assert property (process_ram_write_busy && $past(process_ram_write_busy) |->
    $past(process_ram_write_remaining) - process_ram_write_remaining <= 16'h0004) else $error("write length jump");
  a_tx_flush: assert property ($fell(process_ram_read_abort) |=> !tx_valid)
    else $error("tx not flushed");
endmodule // core_access_bridge_assertions
`default_nettype wire

/* File: sim/opb_core_model.sv */
// OPB core slave: 16-word store, ack after a lag.
// Assumes select is held until ack is taken.
`timescale 1ns/10ps
`default_nettype none
module opb_core_model (
  input wire logic clk, opb_select, opb_rnw,
  input wire logic [2:0] ack_lag,
  input wire logic [3:0] opb_be,
  input wire logic [15:0] opb_abus,
  input wire logic [31:0] opb_dbus_out,
  output logic [31:0] opb_dbus_in,
  output logic opb_xferack
);
  logic [31:0] mem [16] = '{default: 32'h00000000};
  logic [2:0] cnt_q = 3'h0;
  // Released bus inverted so stale data never passes
  assign opb_dbus_in = opb_select ? mem[opb_abus[5:2]] : ~mem[opb_abus[5:2]];
  assign opb_xferack = opb_select && cnt_q >= ack_lag;
  always_ff @(posedge clk) begin
    cnt_q <= opb_select ? cnt_q + 3'h1 : 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (opb_xferack && !opb_rnw && opb_be[i]) begin
        mem[opb_abus[5:2]][i*8 +: 8] <= opb_dbus_out[i*8 +: 8];
      end
    end
  end
endmodule // opb_core_model
`default_nettype wire

/* File: sim/core_access_bridge_test.sv */
// Bench for core_access_bridge with an OPB core model.
// Assumes default ratio and depth; fixed seed.
`timescale 1ns/10ps
`default_nettype none
module core_access_bridge_test;
  logic clk = 1'b0, sys_rst = 1'b1, hsel, hready, hreadyout, hresp, opb_select, opb_rnw, opb_xferack, cmd_wr;
  logic cmd_busy_in, cmd_direction_in, cmd_abort_in, data_wr, core_access_busy, core_access_abort, tx_valid;
  logic core_access_direction, read_window_wr, read_abort_wr, process_ram_read_busy, process_ram_read_abort;
  logic tx_ready, write_window_wr, write_start_wr, write_abort_wr, process_ram_write_busy, rx_valid, rx_ready;
  logic process_ram_write_abort;
  logic [1:0] htrans;
  logic [2:0] hsize, cmd_byte_count_in, core_access_byte_count, ack_lag;
  logic [3:0] opb_be;
  logic [15:0] opb_abus, cmd_target_in, core_access_target, read_window_start, read_window_length;
  logic [15:0] process_ram_read_remaining, process_ram_read_pointer, write_window_start, write_window_length;
  logic [15:0] process_ram_write_remaining, process_ram_write_pointer;
  logic [31:0] haddr, hwdata, hrdata, opb_dbus_out, opb_dbus_in, data_in, core_access_data, tx_data, rx_data;
  logic [31:0] seed = 32'h0000000B, w;
  logic [31:0] mk [3] = '{32'h0000FF00, 32'hFFFF0000, 32'hFFFFFFFF};
  logic [15:0] tg [3] = '{16'h0021, 16'h0026, 16'h0028};
  int n_mismatch = 0, comparisons = 0, ntx;
  core_access_bridge i_core_access_bridge (.*);
  opb_core_model i_opb_core_model (.*);
  assign hready = hreadyout;
  always #25 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  // k: 3 ready, 2 core busy, 1 read busy, 0 write busy
  task automatic wait_for(input int k, input logic v);
    logic [3:0] s;
    repeat (500) begin
      s = {hreadyout, core_access_busy, process_ram_read_busy, process_ram_write_busy};
      if (s[k] !== v) tick();
    end
    chk("wait", s[k], v);
  endtask
  task automatic cmd(input logic b, input logic d, input logic a, input logic [2:0] n, input logic [15:0] t);
    {cmd_busy_in, cmd_direction_in, cmd_abort_in, cmd_byte_count_in, cmd_target_in} = {b, d, a, n, t};
    pulse(cmd_wr);
    tick();
  endtask
  task automatic direct(input logic d, input logic [31:0] a, input logic [31:0] v);
    cmd(1'b0, d, 1'b0, 3'h4, 16'h0000);
    chk("direction", core_access_direction, d);
    {hsel, htrans, haddr, hsize} = {1'b1, 2'h2, a, 3'h2};
    tick();
    {hsel, htrans, hwdata} = {1'b0, 2'h0, v};
    wait_for(3, 1'b1);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {hsel, htrans, haddr, hsize, hwdata, cmd_wr, cmd_busy_in, cmd_direction_in, cmd_abort_in, data_wr} = '0;
    {cmd_byte_count_in, cmd_target_in, data_in, read_window_wr, read_window_start, read_window_length} = '0;
    {read_abort_wr, tx_ready, write_window_wr, write_window_start, write_window_length, write_start_wr} = '0;
    {write_abort_wr, rx_data, rx_valid, ack_lag} = '0;
    tick(10);
    sys_rst = 1'b0;
    tick();
    chk("hreadyout", hreadyout, 1);
    chk("hresp", hresp, 0);
    for (int i = 0; i < 4; i++) begin
      w = rnd();
      ack_lag = w[2:0] & 3'h3;
      direct(1'b0, 32'h00000FF0 + 32'(4 * i), w);
      direct(1'b1, 32'h00000FF0 + 32'(4 * i), 32'h0);
      chk("direct_read", hrdata, w);
    end
    for (int j = 0; j < 3; j++) begin
      data_in = rnd();
      pulse(data_wr);
      cmd(1'b0, 1'b0, 1'b1, 3'h0, 16'h0000);
      chk("abort_clear", core_access_abort, 0);
      for (int d = 0; d < 2; d++) begin
        cmd(1'b1, d[0], 1'b0, 3'(1 << j), tg[j]);
        chk("busy_set", core_access_busy, 1);
        wait_for(2, 1'b0);
      end
      chk("ind_read", core_access_data, data_in & mk[j]);
    end
    {read_window_start, read_window_length} = {16'h0041, 16'h0009};
    pulse(read_window_wr);
    ntx = 0;
    repeat (200) begin
      w = rnd();
      tx_ready = w[0];
      ntx += int'(tx_valid && tx_ready);
      tick();
    end
    chk("tx_words", ntx, 3);
    chk("rd_remaining", process_ram_read_remaining, 0);
    chk("rd_pointer", process_ram_read_pointer, 16'h004C);
    {tx_ready, read_window_start, read_window_length} = {1'b0, 16'h0000, 16'h0100};
    pulse(read_window_wr);
    tick(40);
    pulse(read_abort_wr);
    wait_for(1, 1'b0);
    tick();
    chk("tx_flushed", tx_valid, 0);
    {write_window_start, write_window_length} = {16'h0082, 16'h0006};
    pulse(write_window_wr);
    pulse(write_start_wr);
    tick(20);
    chk("no_write_empty", opb_select, 0);
    rx_data = rnd();
    pulse(rx_valid);
    tick(30);
    rx_data = rnd();
    pulse(rx_valid);
    wait_for(0, 1'b0);
    chk("wr_remaining", process_ram_write_remaining, 0);
    chk("wr_pointer", process_ram_write_pointer, 16'h0088);
    w = rx_data;
    direct(1'b1, 32'h00000084, 32'h0);
    chk("process_ram_word", hrdata, w);
    summarize();
  end
  initial begin
    #2000000;
    n_mismatch++;
    summarize();
  end
endmodule // core_access_bridge_test
bind core_access_bridge core_access_bridge_assertions i_core_access_bridge_assertions (.*);
`default_nettype wire
